// ===== step_dir_ctrl.sv
// Purpose: Step pulse train, direction level, position and motion status.
// Assumes: Pins are asynchronous and pass a two-stage synchroniser.
// Notes: Registers are reached over a classic Wishbone slave.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module step_dir_ctrl #(
   parameter int SETTLE_CYCLES = step_dir_pkg::SETTLE_CYC
) (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [step_dir_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Motor driver pins
   output logic step_o,
   output logic rotation_direction_o,
   output logic rotation_direction_oe_o,
   input wire logic rotation_direction_i,
   output logic at_speed_o,
   output logic at_speed_oe_o,
   input wire logic at_speed_i,
   output logic idle_o,
   // Stop inputs, active low
   input wire logic hold_n_i,
   input wire logic clockwise_end_stop_n_i,
   input wire logic counter_clockwise_end_stop_n_i
);
   import step_dir_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [RATE_W-1:0] clamp(input logic [31:0] v);
      return (v[RATE_W-1:0] < MIN_PERIOD) ? MIN_PERIOD : v[RATE_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic dir_pin;
   logic speed_pin_low;
   logic hold_low;
   logic limit_low;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_ff <= 5'h1F;
         sync2_ff <= 5'h1F;
      end else if (clk_en_i) begin
         sync1_ff <= {counter_clockwise_end_stop_n_i, clockwise_end_stop_n_i,
                      hold_n_i, at_speed_i, rotation_direction_i};
         sync2_ff <= sync1_ff;
      end
   end

   assign dir_pin = sync2_ff[0];
   assign speed_pin_low = ~sync2_ff[1];
   assign hold_low = ~sync2_ff[2];
   assign limit_low = dir_pin ? ~sync2_ff[4] : ~sync2_ff[3];

   ////////////////////////////////////////////////////////////////////////
   logic ack_ff;
   logic [31:0] dat_ff;
   logic wr;
   logic accel_ff;
   logic dir_ff;
   logic free_ff;
   logic [RATE_W-1:0] start_ff;
   logic [RATE_W-1:0] final_ff;
   logic [RATE_W-1:0] accel_step_ff;
   logic [31:0] steps_ff;
   logic [POS_W-1:0] target_ff;
   logic [POS_W-1:0] pos_ff;
   motion_t state_ff;
   logic cont_ff;
   logic decel_ff;
   logic hold_dec_ff;
   logic step_ff;
   logic idle_ff;
   logic spd_n_ff;
   logic [RATE_W-1:0] period_ff;
   logic [31:0] ramp_ff;
   logic [31:0] left_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic start_ev;
   logic target_ev;
   logic end_ev;
   logic [POS_W-1:0] diff;
   logic [31:0] start_steps;
   logic [31:0] wd_ctrl;
   logic [31:0] wd_accel;

   assign wr = cyc_i & stb_i & we_i & ack_ff;
   assign wd_ctrl = merge(32'h0, dat_i, sel_i);
   assign wd_accel = merge({8'h0, accel_step_ff}, dat_i, sel_i);
   assign start_ev = wr && adr_i == ADR_CTRL && state_ff == st_idle &&
                     (wd_ctrl[CTRL_RUN] | wd_ctrl[CTRL_TARGET]);
   assign target_ev = start_ev & wd_ctrl[CTRL_TARGET];
   assign diff = target_ff - pos_ff;
   assign start_steps = target_ev ? (diff[POS_W-1] ? -diff : diff) : steps_ff;
   assign end_ev = (state_ff == st_settle && cnt_ff == '0) ||
                   (state_ff == st_wait && cnt_ff == '0 && limit_low);

   // Answer one cycle after the request; writes land with the ack.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else if (clk_en_i) begin
         ack_ff <= cyc_i & stb_i & ~ack_ff;
         unique case (adr_i)
            ADR_CTRL: dat_ff <= {27'h0, 2'b00, free_ff, dir_ff, accel_ff};
            ADR_START_RATE: dat_ff <= {8'h0, start_ff};
            ADR_FINAL_RATE: dat_ff <= {8'h0, final_ff};
            ADR_ACCEL: dat_ff <= {8'h0, accel_step_ff};
            ADR_STEPS: dat_ff <= steps_ff;
            ADR_TARGET: dat_ff <= target_ff;
            ADR_POSITION: dat_ff <= pos_ff;
            ADR_STATUS: dat_ff <= {26'h0, idle_ff, dir_pin, state_ff == st_wait,
                                   cont_ff, ~spd_n_ff, state_ff != st_idle};
            default: dat_ff <= 32'h0;
         endcase
      end
   end

   // Settings are only changed between motions, except the free-run bit, which a control write can set during one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accel_ff <= 1'b0;
         dir_ff <= 1'b0;
         free_ff <= 1'b0;
         start_ff <= START_RATE_RST;
         final_ff <= FINAL_RATE_RST;
         accel_step_ff <= ACCEL_RST;
         steps_ff <= 32'h0;
         target_ff <= '0;
      end else if (clk_en_i) begin
         if (wr && state_ff == st_idle) begin
            unique case (adr_i)
               ADR_CTRL: begin
                  if (sel_i[0]) begin
                     accel_ff <= dat_i[CTRL_ACCEL];
                     dir_ff <= dat_i[CTRL_DIR];
                  end
               end
               ADR_START_RATE:
                  start_ff <= clamp(merge({8'h0, start_ff}, dat_i, sel_i));
               ADR_FINAL_RATE:
                  final_ff <= clamp(merge({8'h0, final_ff}, dat_i, sel_i));
               ADR_ACCEL: accel_step_ff <= wd_accel[RATE_W-1:0];
               ADR_STEPS: steps_ff <= merge(steps_ff, dat_i, sel_i);
               ADR_TARGET: target_ff <= merge(target_ff, dat_i, sel_i);
               default: ;
            endcase
         end
         if (target_ev) begin
            dir_ff <= diff[POS_W-1];
         end
         if (wr && adr_i == ADR_CTRL && wd_ctrl[CTRL_FREE]) begin
            free_ff <= 1'b1;
         end else if (end_ev) begin
            free_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Motion sequencer.
   logic more;
   logic go_decel;
   logic [RATE_W:0] up;
   logic [RATE_W:0] dn;

   assign more = cont_ff ? 1'b1 : (left_ff != 32'h0);
   assign go_decel = hold_dec_ff | (~cont_ff & (left_ff <= ramp_ff));
   assign up = {1'b0, period_ff} + {1'b0, accel_step_ff};
   assign dn = {1'b0, period_ff} - {1'b0, accel_step_ff};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= st_idle;
         cont_ff <= 1'b0;
         decel_ff <= 1'b0;
         hold_dec_ff <= 1'b0;
         step_ff <= 1'b1;
         idle_ff <= 1'b1;
         period_ff <= FINAL_RATE_RST;
         ramp_ff <= 32'h0;
         left_ff <= 32'h0;
         cnt_ff <= '0;
         pos_ff <= '0;
      end else if (clk_en_i) begin
         if (wr && adr_i == ADR_POSITION && state_ff == st_idle) begin
            pos_ff <= merge(pos_ff, dat_i, sel_i);
         end
         unique case (state_ff)
            st_idle: begin
               if (start_ev) begin
                  idle_ff <= 1'b0;
                  left_ff <= start_steps;
                  cnt_ff <= CNT_W'(SYNC_CYC);
                  state_ff <= st_wait;
               end
            end
            st_wait: begin
               if (cnt_ff != '0) begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end else if (limit_low) begin
                  idle_ff <= 1'b1;
                  state_ff <= st_idle;
               end else if (!hold_low) begin
                  state_ff <= st_first;
               end
            end
            st_first: begin
               cont_ff <= free_ff | speed_pin_low;
               period_ff <= accel_ff ? start_ff : final_ff;
               ramp_ff <= 32'h0;
               decel_ff <= 1'b0;
               hold_dec_ff <= 1'b0;
               if (free_ff | speed_pin_low | (left_ff != 32'h0)) begin
                  step_ff <= 1'b0;
                  cnt_ff <= CNT_W'(PULSE_LOW_CYC - 1);
                  if (!(free_ff | speed_pin_low)) begin
                     left_ff <= left_ff - 32'h1;
                  end
                  pos_ff <= dir_pin ? pos_ff - POS_W'(1) : pos_ff + POS_W'(1);
                  state_ff <= st_low;
               end else begin
                  cnt_ff <= CNT_W'(SETTLE_CYCLES - 1);
                  state_ff <= st_settle;
               end
            end
            st_low: begin
               if (hold_low) begin
                  hold_dec_ff <= 1'b1;
               end
               if (cnt_ff == '0) begin
                  step_ff <= 1'b1;
                  if (limit_low) begin
                     cnt_ff <= CNT_W'(SETTLE_CYCLES - 1);
                     state_ff <= st_settle;
                  end else begin
                     cnt_ff <= CNT_W'(period_ff - MIN_PERIOD);
                     state_ff <= st_high;
                  end
               end else begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end
            end
            st_high: begin
               if (hold_low) begin
                  hold_dec_ff <= 1'b1;
               end
               if (limit_low) begin
                  cnt_ff <= CNT_W'(SETTLE_CYCLES - 1);
                  state_ff <= st_settle;
               end else if (cnt_ff != '0) begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end else if (!more || (hold_dec_ff && hold_low &&
                     (!accel_ff || period_ff >= start_ff))) begin
                  cnt_ff <= CNT_W'(SETTLE_CYCLES - 1);
                  state_ff <= st_settle;
               end else begin
                  step_ff <= 1'b0;
                  cnt_ff <= CNT_W'(PULSE_LOW_CYC - 1);
                  pos_ff <= dir_pin ? pos_ff - POS_W'(1) : pos_ff + POS_W'(1);
                  if (!cont_ff) begin
                     left_ff <= left_ff - 32'h1;
                  end
                  state_ff <= st_low;
                  if (accel_ff) begin
                     if (go_decel) begin
                        decel_ff <= 1'b1;
                        period_ff <= (up > {1'b0, start_ff}) ?
                                     start_ff : up[RATE_W-1:0];
                        if (ramp_ff != 32'h0) begin
                           ramp_ff <= ramp_ff - 32'h1;
                        end
                     end else if (period_ff > final_ff) begin
                        period_ff <= (dn[RATE_W] || dn < {1'b0, final_ff}) ?
                                     final_ff : dn[RATE_W-1:0];
                        ramp_ff <= ramp_ff + 32'h1;
                     end
                  end
               end
            end
            st_settle: begin
               if (cnt_ff == '0) begin
                  idle_ff <= 1'b1;
                  cont_ff <= 1'b0;
                  state_ff <= st_idle;
               end else begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spd_n_ff <= 1'b1;
      end else if (clk_en_i) begin
         spd_n_ff <= ~((state_ff == st_low || state_ff == st_high) &&
                       !decel_ff && period_ff == final_ff);
      end
   end

   assign dat_o = dat_ff;
   assign ack_o = ack_ff;
   assign step_o = step_ff;
   assign idle_o = idle_ff;
   assign rotation_direction_o = dir_ff;
   assign rotation_direction_oe_o = dir_ff;
   assign at_speed_o = spd_n_ff;
   assign at_speed_oe_o = spd_n_ff;
endmodule

// ===== step_dir_ctrl_assertions.sv
// Purpose: Concurrent checks on the step and direction controller pins.
// Assumes: Clock enable held high, so registered outputs move every edge.
// Notes: Low width and settle time are measured by small counters.
`timescale 1ns/1ns
module step_dir_ctrl_assertions #(
   parameter int SETTLE_CYCLES = step_dir_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus handshake
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Motor pins
   input wire logic step_o,
   input wire logic rotation_direction_o,
   input wire logic rotation_direction_oe_o,
   input wire logic at_speed_oe_o,
   input wire logic idle_o
);
   import step_dir_pkg::*;
   int low_cnt_ff;
   int since_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i || step_o) begin
         low_cnt_ff <= 0;
      end else begin
         low_cnt_ff <= low_cnt_ff + 1;
      end
   end
   // Saturates, so a motion refused at a limit still sees a settled motor.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_ff <= SETTLE_CYCLES;
      end else if (!step_o) begin
         since_ff <= 0;
      end else if (since_ff < SETTLE_CYCLES) begin
         since_ff <= since_ff + 1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence step_begin;
      $fell(step_o);
   endsequence
   sequence bus_request;
      cyc_i && stb_i && !ack_o;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   pulse_width_a: assert property (
      $rose(step_o) |-> low_cnt_ff == PULSE_LOW_CYC)
      else $error("step low time differs from fixed width");
   pulse_bound_a: assert property (
      !step_o |-> low_cnt_ff < PULSE_LOW_CYC)
      else $error("step stayed low too long");
   idle_motion_a: assert property (
      step_begin |-> !idle_o [*8])
      else $error("idle high while stepping");
   settle_wait_a: assert property (
      $rose(idle_o) |-> since_ff >= SETTLE_CYCLES)
      else $error("idle rose before settle time");
   dir_stable_a: assert property (
      !step_o |-> $stable(rotation_direction_o))
      else $error("direction moved during a step");
   dir_weak_a: assert property (
      !rotation_direction_oe_o |-> !rotation_direction_o)
      else $error("direction driven high strongly");
   slew_motion_a: assert property (
      !at_speed_oe_o |-> !idle_o)
      else $error("at speed low outside a motion");
   bus_answer_a: assert property (
      bus_request |=> ack_o ##1 !ack_o)
      else $error("bus acknowledge not a single cycle");
endmodule
bind step_dir_ctrl step_dir_ctrl_assertions #(
   .SETTLE_CYCLES(SETTLE_CYCLES)
) checker_i (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .cyc_i(cyc_i),
   .stb_i(stb_i),
   .ack_o(ack_o),
   .step_o(step_o),
   .rotation_direction_o(rotation_direction_o),
   .rotation_direction_oe_o(rotation_direction_oe_o),
   .at_speed_oe_o(at_speed_oe_o),
   .idle_o(idle_o)
);

// ===== step_dir_pkg.sv
// Purpose: Constants and types for the step and direction motion block.
// Assumes: 50 MHz system clock, classic Wishbone register access.
// Notes: Rates are step periods counted in system clock cycles.
// Summary of operation
// - One step pulse per commanded step
// - Step output idles high, falls per step
// - Fixed low time, high for the rest
// - Direction high counter-clockwise, low clockwise
// - Direction high decrements, low increments position
// - Position counted in step increments only
// - Negative direction released high, may be overridden
// - Ramp start rate to final rate, hold
// - Decelerate to start rate as steps end
// - Idle output low for whole motion
// - Wait 5 ms before idle returns high
// - At-speed low only while slewing at final rate
// - Sample at-speed pin before first step
// - Continuous mode runs countless, still tracks position
// - Continuous motion ends only through hold input or a limit
// - Free-run selection cleared after every motion
// - Hold low decelerates, then stops per step
// - Hold low at start waits without stepping
// - Limit in direction abandons motion at once
package step_dir_pkg;
   localparam int CLK_MHZ = 50;
   localparam int PULSE_LOW_NS = 10000;
   localparam int PULSE_LOW_CYC = (PULSE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_MS = 5;
   localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
   // A start waits this long so a direction it writes has crossed the
   // pin synchroniser before the first step and the limit check.
   localparam int SYNC_CYC = 2;
   localparam int RATE_W = 24;
   localparam int POS_W = 32;
   localparam int ADR_W = 5;
   localparam int CNT_W = 24;
   localparam logic [RATE_W-1:0] MIN_PERIOD = RATE_W'(PULSE_LOW_CYC + 1);
   // Byte addresses of the registers.
   localparam logic [ADR_W-1:0] ADR_CTRL = 5'h00;
   localparam logic [ADR_W-1:0] ADR_START_RATE = 5'h04;
   localparam logic [ADR_W-1:0] ADR_FINAL_RATE = 5'h08;
   localparam logic [ADR_W-1:0] ADR_ACCEL = 5'h0C;
   localparam logic [ADR_W-1:0] ADR_STEPS = 5'h10;
   localparam logic [ADR_W-1:0] ADR_TARGET = 5'h14;
   localparam logic [ADR_W-1:0] ADR_POSITION = 5'h18;
   localparam logic [ADR_W-1:0] ADR_STATUS = 5'h1C;
   // Control register bits.
   localparam int CTRL_ACCEL = 0;
   localparam int CTRL_DIR = 1;
   localparam int CTRL_FREE = 2;
   localparam int CTRL_RUN = 3;
   localparam int CTRL_TARGET = 4;
   // Status register bits.
   localparam int ST_BUSY = 0;
   localparam int ST_AT_SPEED = 1;
   localparam int ST_CONT = 2;
   localparam int ST_WAIT = 3;
   localparam int ST_DIR_PIN = 4;
   localparam int ST_IDLE = 5;
   // Reset values.
   localparam logic [RATE_W-1:0] START_RATE_RST = 24'h00C350;
   localparam logic [RATE_W-1:0] FINAL_RATE_RST = 24'h0009C4;
   localparam logic [RATE_W-1:0] ACCEL_RST = 24'h000064;
   typedef enum logic [2:0] {
      st_idle, st_wait, st_first, st_low, st_high, st_settle
   } motion_t;
endpackage

// ===== stepper_driver_model.sv
// Purpose: Motor power driver stand-in with pull-ups on the shared pins.
// Assumes: A released pin floats to the pull-up level.
// Notes: Counts pulses and tracks a signed shaft position.
`timescale 1ns/1ns
module stepper_driver_model (
   // Controller pins
   input wire logic step_i,
   input wire logic dir_drive_i,
   input wire logic dir_oe_i,
   input wire logic slew_drive_i,
   input wire logic slew_oe_i,
   // Bench overrides, pulling a released pin low
   input wire logic pull_dir_i,
   input wire logic pull_slew_i,
   // Resolved pins and motor state
   output logic dir_pin_o,
   output logic slew_pin_o,
   output int pulses_o,
   output int shaft_o
);
   assign dir_pin_o = dir_oe_i ? !pull_dir_i : dir_drive_i;
   assign slew_pin_o = slew_oe_i ? !pull_slew_i : slew_drive_i;
   initial pulses_o = 0;
   initial shaft_o = 0;
   always @(negedge step_i) begin
      pulses_o = pulses_o + 1;
      shaft_o = dir_pin_o ? shaft_o - 1 : shaft_o + 1;
   end
endmodule

// ===== stepper_step_direction_status_bench.sv
// Purpose: Self-checking bench for the step and direction controller.
// Assumes: Clock enable tied high; settle shortened to 20 cycles.
// Notes: Rates are kept low so each motion ends in a few thousand cycles.
`timescale 1ns/1ns
module stepper_step_direction_status_bench;
   import step_dir_pkg::*;
   localparam int LIMIT_CYC = 60000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [ADR_W-1:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd;
   logic ack_o, step_o, dir_o, dir_oe, at_o, at_oe, idle_o, dir_pin, at_pin;
   logic hold_n = 1'b1;
   logic cw_n = 1'b1;
   logic ccw_n = 1'b1;
   logic pull_dir = 1'b0;
   logic pull_at = 1'b0;
   logic step_q = 1'b1;
   logic idle_q = 1'b1;
   logic slew_seen = 1'b0;
   int pulses, shaft, p0;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int gap = 0;
   int nf = 0;
   int fg = 0;
   int lg = 0;
   int mn = 0;
   always #10 clk_i = ~clk_i;
   step_dir_ctrl #(.SETTLE_CYCLES(20)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .step_o(step_o), .rotation_direction_o(dir_o),
      .rotation_direction_oe_o(dir_oe), .rotation_direction_i(dir_pin),
      .at_speed_o(at_o), .at_speed_oe_o(at_oe), .at_speed_i(at_pin),
      .idle_o(idle_o), .hold_n_i(hold_n),
      .clockwise_end_stop_n_i(cw_n),
      .counter_clockwise_end_stop_n_i(ccw_n)
   );
   stepper_driver_model motor (
      .step_i(step_o), .dir_drive_i(dir_o), .dir_oe_i(dir_oe),
      .slew_drive_i(at_o), .slew_oe_i(at_oe), .pull_dir_i(pull_dir),
      .pull_slew_i(pull_at), .dir_pin_o(dir_pin), .slew_pin_o(at_pin),
      .pulses_o(pulses), .shaft_o(shaft)
   );
   ////////////////////////////////////////////////////////////////////////
   // Step intervals are measured per motion, cleared when idle falls.
   always @(posedge clk_i) begin
      step_q <= step_o;
      idle_q <= idle_o;
      gap <= gap + 1;
      cycles <= cycles + 1;
      if (idle_q && !idle_o) begin
         nf <= 0;
         mn <= LIMIT_CYC;
         slew_seen <= 1'b0;
      end else if (step_q && !step_o) begin
         nf <= nf + 1;
         gap <= 1;
         if (nf == 1) fg <= gap;
         if (nf >= 1 && gap < mn) mn <= gap;
      end
      // The last step's gap runs until idle rises, so it takes in the settle wait.
      if (!idle_q && idle_o) lg <= gap;
      if (at_oe === 1'b0) slew_seen <= 1'b1;
      if (cycles == LIMIT_CYC) begin
         errors = errors + 1;
         close_out();
      end
   end
   task automatic close_out;
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         errors++;
      end
   endtask
   task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                     input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [ADR_W-1:0] a, input logic [31:0] exp,
                       input string what);
      wb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   // Direction is set by a first write so the pin settles before a step.
   task automatic start(input logic [31:0] steps, input logic [31:0] ctrl);
      p0 = pulses;
      wb(1'b1, ADR_STEPS, steps);
      wb(1'b1, ADR_CTRL, ctrl & 32'h3);
      repeat (4) @(posedge clk_i);
      wb(1'b1, ADR_CTRL, ctrl);
   endtask
   task automatic finish(input int exp);
      repeat (4) @(posedge clk_i);
      while (idle_o !== 1'b1) @(posedge clk_i);
      if (exp >= 0) chk("pulses", 32'(p0 + exp), 32'(pulses));
      rchk(ADR_POSITION, 32'(shaft), "position");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(ADR_START_RATE, 32'(START_RATE_RST), "start rate");
      rchk(ADR_FINAL_RATE, 32'(FINAL_RATE_RST), "final rate");
      rchk(ADR_ACCEL, 32'(ACCEL_RST), "accel");
      wb(1'b1, ADR_START_RATE, 32'h3E8);
      wb(1'b1, ADR_FINAL_RATE, 32'h258);
      start(32'h3, 32'h08);
      finish(3);
      start(32'h2, 32'h0A);
      finish(2);
      wb(1'b1, ADR_CTRL, 32'h02);
      pull_dir <= 1'b1;
      start(32'h1, 32'h0A);
      finish(1);
      pull_dir <= 1'b0;
      cw_n <= 1'b0;
      start(32'h1, 32'h08);
      finish(0);
      cw_n <= 1'b1;
      start(32'h8, 32'h08);
      while (pulses < p0 + 2) @(posedge clk_i);
      cw_n <= 1'b0;
      finish(2);
      cw_n <= 1'b1;
      hold_n <= 1'b0;
      start(32'h1, 32'h08);
      repeat (2000) @(posedge clk_i);
      chk("held pulses", 32'(p0), 32'(pulses));
      chk("held idle", 32'h0, {31'h0, idle_o});
      hold_n <= 1'b1;
      finish(1);
      start(32'hC, 32'h09);
      finish(12);
      chk("first period", 32'h3E8, 32'(fg));
      chk("slew period", 32'h258, 32'(mn));
      chk("last period", 32'h3E8 + 32'h14, 32'(lg));
      chk("slew seen", 32'h1, {31'h0, slew_seen});
      wb(1'b1, ADR_CTRL, 32'h04);
      start(32'h1, 32'h08);
      while (pulses < p0 + 4) @(posedge clk_i);
      hold_n <= 1'b0;
      finish(-1);
      hold_n <= 1'b1;
      rchk(ADR_CTRL, 32'h0, "free after");
      pull_at <= 1'b1;
      start(32'h1, 32'h08);
      while (pulses < p0 + 3) @(posedge clk_i);
      pull_at <= 1'b0;
      hold_n <= 1'b0;
      finish(-1);
      hold_n <= 1'b1;
      start(32'h1, 32'h08);
      finish(1);
      close_out();
   end
endmodule
